// *** tmr2_pkg.sv ***
/*
  tmr2_pkg: register map, field positions, reset values and carrier types
  for the capture/reload/up-down timer block.
  assumes: one 20 MHz system clock, synchronous reset, Avalon-MM slave access.
*/
package tmr2_pkg;

  // register byte addresses on the avalon bus (consecutive, one per register)
  localparam logic [7:0] TMR2_IDX_MAIN   = 8'hC8;  // main control / flags
  localparam logic [7:0] TMR2_IDX_MODE   = 8'hC9;  // mode control
  localparam logic [7:0] TMR2_IDX_RLD_LO = 8'hCA;  // reload value low
  localparam logic [7:0] TMR2_IDX_RLD_HI = 8'hCB;  // reload value high
  localparam logic [7:0] TMR2_IDX_CNT_LO = 8'hCC;  // count low byte
  localparam logic [7:0] TMR2_IDX_CNT_HI = 8'hCD;  // count high byte
  localparam logic [7:0] TMR2_IDX_CLKCFG = 8'hCE;  // clock config (prescaler)

  // main control bit positions
  localparam int TMR2_B_TF    = 7;  // overflow flag
  localparam int TMR2_B_EXF   = 6;  // external flag
  localparam int TMR2_B_RCLK  = 5;  // rx clock select
  localparam int TMR2_B_TX_CLOCK_SELECT  = 4;  // tx clock select
  localparam int TMR2_B_EXEN  = 3;  // external trigger enable
  localparam int TMR2_B_RUN   = 2;  // run control
  localparam int TMR2_B_CT    = 1;  // timer/counter select
  localparam int TMR2_B_CPRL  = 0;  // capture/reload select

  // mode control bit positions
  localparam int TMR2_B_OE    = 1;  // clock out enable
  localparam int TMR2_B_DOWN_COUNT_ENABLE  = 0;  // down count enable

  // clock config: prescaler in [3:0], double speed [4], compat mode [5]
  localparam int TMR2_B_X2    = 4;
  localparam int TMR2_B_COMPAT= 5;
  localparam int TMR2_PS_W    = 4;

  localparam logic [7:0]  TMR2_RST_BYTE = 8'h00;
  localparam logic [15:0] TMR2_MIN      = 16'h0000;
  localparam logic [15:0] TMR2_MAX      = 16'hFFFF;
  localparam logic [7:0]  TMR2_MODE_MSK = 8'h03;
  localparam logic [7:0]  TMR2_CFG_MSK  = 8'h3F;

  // decoded operating mode
  typedef enum logic [2:0] {
    TMR2_OFF,
    TMR2_RELOAD,
    TMR2_UPDOWN,
    TMR2_CAPTURE,
    TMR2_BAUD
  } tmr2_mode_t;

  // main control fields
  typedef struct packed {
    logic tf;
    logic exf;
    logic rclk;
    logic tx_clock_select;
    logic exen;
    logic run;
    logic ct;
    logic cprl;
  } tmr2_ctrl_t;

endpackage : tmr2_pkg

// *** tmr2_timer.sv ***
/*
  tmr2_timer: 16-bit timer/counter with capture, auto-reload, up/down count,
  serial clock supply and toggling clock out, behind an avalon-mm slave.
  assumes: count and trigger pins are asynchronous and are synchronised here;
  the serial port consumes the one-cycle rx/tx clock pulses; the bus master
  holds each request until it sees waitrequest low, and every access takes
  two clocks; software clears both flags itself; hardware sets them, and toggles the external flag in up/down mode.
*/
// Our own choice: the Avalon-MM register port.
module tmr2_timer
  import tmr2_pkg::*;
(
  input  wire logic        clk_sys,          // 20 MHz system clock
  input  wire logic        rst,              // synchronous active-high reset
  input  wire logic [7:0]  avs_address,      // byte address
  input  wire logic        avs_read,         // read strobe
  input  wire logic        avs_write,        // write strobe
  input  wire logic [31:0] avs_writedata,    // write data, low byte used
  output logic      [31:0] avs_readdata,     // read data
  output logic             avs_waitrequest,  // stall until answer ready
  input  wire logic        count_input_pin_i,         // count pin input level
  output logic             count_input_pin_o,         // clock out level
  output logic             count_input_pin_oe_n,      // low while driving clock out
  input  wire logic        trigger_direction_input,   // trigger/direction pin
  input  wire logic        timer1_overflow,           // timer1 overflow pulse
  output logic             rx_clock,                  // serial rx clock pulse
  output logic             tx_clock,                  // serial tx clock pulse
  output logic             timer_irq                  // interrupt request level
);

  tmr2_ctrl_t  ctrl;           // main control/flags
  logic [7:0]  mode_reg;       // mode control
  logic [7:0]  clk_cfg;        // prescaler and speed bits
  logic [15:0] count;          // count high:low
  logic [15:0] reload;         // capture/reload high:low
  logic [1:0]  cnt_sync;       // count pin synchroniser
  logic [1:0]  trg_sync;       // trigger pin synchroniser
  logic        cnt_prev;       // previous synced count sample
  logic        trg_prev;       // previous synced trigger sample
  logic [TMR2_PS_W-1:0] ps_cnt;  // prescale divider
  logic        ps_half;        // extra halving for compat double speed
  tmr2_mode_t  mode;           // decoded mode

  wire logic cnt_lvl = cnt_sync[1];
  wire logic trg_lvl = trg_sync[1];
  wire logic serial  = ctrl.rclk | ctrl.tx_clock_select;
  wire logic clk_out_en = mode_reg[TMR2_B_OE] & ~ctrl.ct;
  wire logic down_count_enable    = mode_reg[TMR2_B_DOWN_COUNT_ENABLE];

  // mode decode: serial and clock-out bits take priority over capture select.
  // a cleared run bit beats everything, so a stopped timer never ticks, wraps
  // or reloads, whatever the other control bits say
  always_comb
  begin
    if (!ctrl.run)
      mode = TMR2_OFF;
    else if (serial || mode_reg[TMR2_B_OE])
      mode = TMR2_BAUD;
    else if (ctrl.cprl)
      mode = TMR2_CAPTURE;
    else if (down_count_enable && ctrl.exen)
      mode = TMR2_UPDOWN;
    else
      mode = TMR2_RELOAD;
  end

  // pin synchronisers, two flops before any logic.
  // they reset to the idle-high pin level so that releasing reset never looks
  // like a falling edge; only the second stage feeds the edge detectors
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt_sync <= 2'h3;
      trg_sync <= 2'h3;
      cnt_prev <= 1'b1;
      trg_prev <= 1'b1;
    end
    else
    begin
      cnt_sync <= {cnt_sync[0], count_input_pin_i};
      trg_sync <= {trg_sync[0], trigger_direction_input};
      cnt_prev <= cnt_lvl;
      trg_prev <= trg_lvl;
    end
  end

  // a falling edge is one high sample followed by one low sample, so each pin
  // level must stand for a full clock to be seen; latency is three clocks
  wire logic trg_fall = trg_prev & ~trg_lvl;
  wire logic cnt_fall = cnt_prev & ~cnt_lvl;

  // prescaler tick; generator modes bypass it.
  // fast mode uses the divider only with double speed set, compat mode always;
  // the divider runs free, so the first tick after a start lands within one
  // prescale period rather than exactly on it
  logic ps_use;
  logic ps_wrap;
  always_comb
  begin
    ps_use  = clk_cfg[TMR2_B_COMPAT] | clk_cfg[TMR2_B_X2];
    ps_wrap = (ps_cnt == clk_cfg[TMR2_PS_W-1:0]);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ps_cnt  <= '0;
      ps_half <= 1'b0;
    end
    else if (ps_wrap)
    begin
      ps_cnt  <= '0;
      ps_half <= ~ps_half;
    end
    else
      ps_cnt <= ps_cnt + 1'b1;
  end

  // compat plus double speed waits for two prescale wraps, which doubles the
  // timeout as the speed bit promises in that mode
  logic timer_tick;
  always_comb
  begin
    if (mode == TMR2_BAUD || !ps_use)
      timer_tick = 1'b1;
    else if (clk_cfg[TMR2_B_COMPAT] && clk_cfg[TMR2_B_X2])
      timer_tick = ps_wrap & ps_half;
    else
      timer_tick = ps_wrap;
  end

  // count tick: pin edges in counter mode, else timer ticks.
  // direction is only ever down in up/down mode with the trigger pin low;
  // underflow means stepping down from the reload value, not from zero
  logic tick;
  logic up;
  logic ovf;
  logic unf;
  always_comb
  begin
    tick = (mode != TMR2_OFF) && (ctrl.ct ? cnt_fall : timer_tick);
    up   = (mode != TMR2_UPDOWN) || trg_lvl;
    ovf  = tick && up && (count == TMR2_MAX);
    unf  = tick && !up && (count == reload);
  end

  // external trigger: ignored while clocking the serial port for reload.
  // in the generator modes it still sets the external flag, which lets software
  // use the pin as a spare interrupt source; up/down mode uses it as direction
  wire logic ext_evt = ctrl.exen && trg_fall && (mode != TMR2_OFF) && (mode != TMR2_UPDOWN);

  // bus qualifiers: a write lands only at the edge where waitrequest is seen low,
  // so a stalled write never changes state twice
  wire logic       bus_req = avs_read || avs_write;          // any strobe
  wire logic       bus_wr  = avs_write && !avs_waitrequest;  // write commit edge
  wire logic       rd_load = avs_read && avs_waitrequest;    // first read cycle
  wire logic [7:0] wbyte   = avs_writedata[7:0];             // only the low byte is used

  // counter datapath and capture register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      count  <= TMR2_MIN;
      reload <= TMR2_MIN;
    end
    else
    begin
      if (ovf)
      begin
        if (mode == TMR2_CAPTURE)
          count <= TMR2_MIN;
        else
          count <= reload;
      end
      else if (unf)
        count <= TMR2_MAX;
      else if (ext_evt && !serial && mode == TMR2_RELOAD)
        count <= reload;
      else if (tick)
        count <= up ? count + 16'h0001 : count - 16'h0001;
      // limitation: a count write that meets a tick or a reload is lost,
      // so software stops the timer before it loads a new count
      else if (bus_wr && avs_address == TMR2_IDX_CNT_LO)
        count[7:0] <= wbyte;
      else if (bus_wr && avs_address == TMR2_IDX_CNT_HI)
        count[15:8] <= wbyte;
      if (ext_evt && !serial && mode == TMR2_CAPTURE)
        reload <= count;
      else if (bus_wr && avs_address == TMR2_IDX_RLD_LO)
        reload[7:0] <= wbyte;
      else if (bus_wr && avs_address == TMR2_IDX_RLD_HI)
        reload[15:8] <= wbyte;
    end
  end

  // control register and flags; hardware set wins over software clear.
  // a clear that meets a set in the same cycle is dropped: losing an event
  // is worse than software having to clear once more
  logic next_tf;
  logic next_exf;
  always_comb
  begin
    next_tf  = ctrl.tf;
    next_exf = ctrl.exf;
    if (bus_wr && avs_address == TMR2_IDX_MAIN)
    begin
      next_tf  = wbyte[TMR2_B_TF];
      next_exf = wbyte[TMR2_B_EXF];
    end
    if ((ovf || unf) && !serial && !mode_reg[TMR2_B_OE])
      next_tf = 1'b1;
    if (mode == TMR2_UPDOWN && (ovf || unf))
      next_exf = ~ctrl.exf;
    else if (ext_evt)
      next_exf = 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ctrl <= tmr2_ctrl_t'(TMR2_RST_BYTE);
    else
    begin
      if (bus_wr && avs_address == TMR2_IDX_MAIN)
        ctrl <= tmr2_ctrl_t'(wbyte);
      ctrl.tf  <= next_tf;
      ctrl.exf <= next_exf;
    end
  end

  // mode and clock config registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mode_reg <= TMR2_RST_BYTE;
      clk_cfg  <= TMR2_RST_BYTE;
    end
    else if (bus_wr && avs_address == TMR2_IDX_MODE)
      mode_reg <= wbyte & TMR2_MODE_MSK;
    else if (bus_wr && avs_address == TMR2_IDX_CLKCFG)
      clk_cfg <= wbyte & TMR2_CFG_MSK;
  end

  // serial clocks and clock out pin.
  // the serial pulses trail the overflow by one clock; the pin toggles only
  // while it is driven, so it starts from a known level after reset
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rx_clock             <= 1'b0;
      tx_clock             <= 1'b0;
      count_input_pin_o    <= 1'b0;
      count_input_pin_oe_n <= 1'b1;
    end
    else
    begin
      rx_clock <= ctrl.rclk ? ovf : timer1_overflow;
      tx_clock <= ctrl.tx_clock_select ? ovf : timer1_overflow;
      count_input_pin_oe_n <= ~clk_out_en;
      if (clk_out_en && ovf)
        count_input_pin_o <= ~count_input_pin_o;
    end
  end

  // interrupt level; external flag silent in up/down mode, where it only
  // serves as the seventeenth count bit
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      timer_irq <= 1'b0;
    else
      timer_irq <= ctrl.tf | (ctrl.exf & ~down_count_enable);
  end

  // avalon slave: waitrequest is a flop, high while idle and in the first cycle
  // of a request, low for exactly the second; the edge at which the master sees
  // it low ends the transfer. every access costs two clocks, but no path runs
  // from the strobes straight back to the master
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      avs_waitrequest <= 1'b1;                   // stall until a request is seen
    else if (bus_req && avs_waitrequest)
      avs_waitrequest <= 1'b0;                   // answer in the second cycle
    else
      avs_waitrequest <= 1'b1;                   // idle, or transfer just ended
  end

  // read mux; unmapped addresses read zero.
  // loaded only in the first cycle of a read, so the data stand until the next read
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      avs_readdata <= 32'h0000_0000;
    else if (rd_load)
    begin
      // the answer edge comes one clock later and sees this value
      unique case (avs_address)
        TMR2_IDX_MAIN:   avs_readdata <= {24'h000000, ctrl};
        TMR2_IDX_MODE:   avs_readdata <= {24'h000000, mode_reg};
        TMR2_IDX_RLD_LO: avs_readdata <= {24'h000000, reload[7:0]};
        TMR2_IDX_RLD_HI: avs_readdata <= {24'h000000, reload[15:8]};
        TMR2_IDX_CNT_LO: avs_readdata <= {24'h000000, count[7:0]};
        TMR2_IDX_CNT_HI: avs_readdata <= {24'h000000, count[15:8]};
        TMR2_IDX_CLKCFG: avs_readdata <= {24'h000000, clk_cfg};
        default:         avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : tmr2_timer

// *** tmr2_timer_monitor.sv ***
/*
  tmr2_timer_monitor: port-level checks for the timer block.
  assumes: one clock, sync reset, bound to each tmr2_timer.
*/
module tmr2_timer_monitor
  import tmr2_pkg::*;
(
  input wire logic        clk_sys,              // clock
  input wire logic        rst,                  // sync reset
  input wire logic [7:0]  avs_address,          // address
  input wire logic        avs_read,             // read
  input wire logic        avs_write,            // write
  input wire logic [31:0] avs_readdata,         // read data
  input wire logic        avs_waitrequest,      // stall
  input wire logic        count_input_pin_o,    // clock out
  input wire logic        count_input_pin_oe_n, // pin drive, low
  input wire logic        rx_clock,             // rx pulse
  input wire logic        tx_clock,             // tx pulse
  input wire logic        timer_irq             // irq level
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic req = avs_read || avs_write; // any strobe
  chk_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("new request not stalled");
  chk_wait_once: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("stall longer than one cycle");
  // the irq only drops by software or reset; the up/down toggle of the external flag is masked from it
  chk_irq_sticky: assert property ($fell(timer_irq) |-> $past(avs_write) || $past(avs_write, 2) || $past(rst))
    else $error("irq dropped without a write");
  chk_oe_write: assert property ($fell(count_input_pin_oe_n) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("clock out enabled without a write");
  chk_rd_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  chk_rd_unmap: assert property (avs_read && !avs_waitrequest
    && (avs_address < TMR2_IDX_MAIN || avs_address > TMR2_IDX_CLKCFG)
    |-> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  // outputs are quiet right after a reset edge
  chk_reset_vals: assert property (disable iff (1'b0) rst |=> !timer_irq && count_input_pin_oe_n && !rx_clock
    && !tx_clock && !count_input_pin_o)
    else $error("outputs not at reset level");
  chk_rd_hold: assert property (!req && !$past(rst) |-> $stable(avs_readdata))
    else $error("read data moved while idle");
  cov_irq: cover property ($rose(timer_irq));
  cov_rx: cover property (rx_clock);
  cov_pin: cover property ($changed(count_input_pin_o));
endmodule : tmr2_timer_monitor

bind tmr2_timer tmr2_timer_monitor u_mon (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .count_input_pin_o(count_input_pin_o), .count_input_pin_oe_n(count_input_pin_oe_n), .rx_clock(rx_clock),
  .tx_clock(tx_clock), .timer_irq(timer_irq));

// *** tmr2_pins_model.sv ***
/*
  tmr2_pins_model: count pin, trigger/direction pin and timer1 source.
  assumes: tasks are called right after a rising clock edge.
*/
module tmr2_pins_model
  import tmr2_pkg::*;
(
  input  wire logic clk_sys,  // clock
  input  wire logic pin_o,    // timer clock out
  input  wire logic pin_oe_n, // low while timer drives pin
  output logic      pin_i,    // resolved count pin
  output logic      trig,     // trigger/direction level
  output logic      t1_ovf    // timer1 overflow pulse
);
  logic ext; // far side level on the count pin
  // timer wins the pin while enabled, else our level shows
  assign pin_i = pin_oe_n ? ext : pin_o;
  initial
  begin
    ext = 1'b1;
    trig = 1'b1;
    t1_ovf = 1'b0;
  end
  // low level held 4 clocks, high 8, so the sampler sees each
  task automatic count_fall();
    ext <= 1'b0;
    repeat (4) @(posedge clk_sys);
    ext <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask : count_fall
  task automatic trig_fall();
    trig <= 1'b0;
    repeat (4) @(posedge clk_sys);
    trig <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask : trig_fall
  task automatic set_dir(input logic v);
    trig <= v;
    repeat (8) @(posedge clk_sys);
  endtask : set_dir
  task automatic t1_pulse();
    t1_ovf <= 1'b1;
    @(posedge clk_sys);
    t1_ovf <= 1'b0;
  endtask : t1_pulse
endmodule : tmr2_pins_model

// *** tb_timer2_capture_reload_counter.sv ***
/*
  tb_timer2_capture_reload_counter: register-level tests of the timer.
  assumes: avalon slave answers after one stall, pins via model.
*/
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_timer2_capture_reload_counter
  import tmr2_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0; // 20 MHz
  logic        rst     = 1'b1; // sync reset
  logic [7:0]  adr     = 8'h00;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic [31:0] wdat    = 32'h00000000;
  logic [31:0] rdat;
  logic        wait_rq, pin_i, pin_o, oe_n, trig, t1, rxc, txc, irq;
  int          errors, n_checks, n_rx, n_tx, n_tog, tog0, n_cyc;
  logic        pin_prev = 1'b0; // last clock-out level seen
  always #25 clk_sys = ~clk_sys;
  tmr2_timer DUT (.clk_sys(clk_sys), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wait_rq), .count_input_pin_i(pin_i),
    .count_input_pin_o(pin_o), .count_input_pin_oe_n(oe_n), .trigger_direction_input(trig),
    .timer1_overflow(t1), .rx_clock(rxc), .tx_clock(txc), .timer_irq(irq));
  tmr2_pins_model P (.clk_sys(clk_sys), .pin_o(pin_o), .pin_oe_n(oe_n), .pin_i(pin_i), .trig(trig), .t1_ovf(t1));
  // pulse and toggle counters for the serial and clock-out paths
  always @(posedge clk_sys)
  begin
    if (rxc === 1'b1) n_rx++;
    if (txc === 1'b1) n_tx++;
    if (pin_o !== pin_prev) n_tog++;
    pin_prev <= pin_o;
  end
  task automatic summarize();
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  // one avalon access: the request stands until a rising edge samples waitrequest
  // low, read data are taken at that edge, then one edge passes before the next
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    adr  <= a;
    wdat <= {24'h000000, d};
    wr   <= w;
    rd   <= !w;
    @(posedge clk_sys);
    while (wait_rq !== 1'b0)
      @(posedge clk_sys);
    q = rdat[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wreg
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK(nm, e, q)
  endtask : rchk
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    summarize();
  end
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rchk("mode_rst", TMR2_IDX_MODE, 8'h00);
    rchk("main_rst", TMR2_IDX_MAIN, 8'h00);
    wreg(8'hD0, 8'h5A);
    rchk("unmapped", 8'hD0, 8'h00);
    // capture in counter mode: a quiet count pin keeps values fixed
    wreg(TMR2_IDX_MAIN, 8'h0F);
    wreg(TMR2_IDX_CNT_LO, 8'h34);
    wreg(TMR2_IDX_CNT_HI, 8'h12);
    P.trig_fall();
    rchk("cap_lo", TMR2_IDX_RLD_LO, 8'h34);
    rchk("cap_hi", TMR2_IDX_RLD_HI, 8'h12);
    rchk("cap_flag", TMR2_IDX_MAIN, 8'h4F);
    `CHK("irq_exf", 1'b1, irq)
    repeat (3) P.count_fall();
    rchk("cnt_edges", TMR2_IDX_CNT_LO, 8'h37);
    wreg(TMR2_IDX_CNT_LO, 8'hFF);
    wreg(TMR2_IDX_CNT_HI, 8'hFF);
    P.count_fall();
    rchk("cap_wrap", TMR2_IDX_CNT_HI, 8'h00);
    rchk("cap_tf", TMR2_IDX_MAIN, 8'hCF);
    wreg(TMR2_IDX_MAIN, 8'h0A);
    rchk("flag_clr", TMR2_IDX_MAIN, 8'h0A);
    `CHK("irq_clr", 1'b0, irq)
    // auto-reload, first with the run bit clear
    wreg(TMR2_IDX_RLD_LO, 8'h78);
    wreg(TMR2_IDX_RLD_HI, 8'h56);
    wreg(TMR2_IDX_CNT_LO, 8'h11);
    wreg(TMR2_IDX_CNT_HI, 8'h11);
    P.count_fall();
    rchk("stopped", TMR2_IDX_CNT_LO, 8'h11);
    wreg(TMR2_IDX_MAIN, 8'h0E);
    P.trig_fall();
    rchk("trg_rld", TMR2_IDX_CNT_LO, 8'h78);
    rchk("trg_flag", TMR2_IDX_MAIN, 8'h4E);
    wreg(TMR2_IDX_CNT_LO, 8'hFF);
    wreg(TMR2_IDX_CNT_HI, 8'hFF);
    P.count_fall();
    rchk("ovf_rld", TMR2_IDX_CNT_HI, 8'h56);
    rchk("ovf_flag", TMR2_IDX_MAIN, 8'hCE);
    // up/down: count sits at the reload value, so a down step underflows
    wreg(TMR2_IDX_MAIN, 8'h0E);
    wreg(TMR2_IDX_MODE, 8'h01);
    P.set_dir(1'b0);
    P.count_fall();
    rchk("dn_top", TMR2_IDX_CNT_LO, 8'hFF);
    rchk("dn_flag", TMR2_IDX_MAIN, 8'hCE);
    wreg(TMR2_IDX_MAIN, 8'h4E);
    @(posedge clk_sys);
    `CHK("irq_ud", 1'b0, irq)
    P.set_dir(1'b1);
    P.count_fall();
    rchk("up_rld", TMR2_IDX_CNT_HI, 8'h56);
    rchk("up_flag", TMR2_IDX_MAIN, 8'h8E);
    // serial clocks: timer1 first, then our own overflows on rx only
    wreg(TMR2_IDX_MODE, 8'h00);
    wreg(TMR2_IDX_MAIN, 8'h00);
    P.t1_pulse();
    repeat (4) @(posedge clk_sys);
    `CHK("rx_t1", 1, n_rx)
    `CHK("tx_t1", 1, n_tx)
    wreg(TMR2_IDX_RLD_LO, 8'hF0);
    wreg(TMR2_IDX_RLD_HI, 8'hFF);
    wreg(TMR2_IDX_CNT_LO, 8'hF0);
    wreg(TMR2_IDX_CNT_HI, 8'hFF);
    wreg(TMR2_IDX_MAIN, 8'h24);
    repeat (100) @(posedge clk_sys);
    `CHK("rx_own", 1'b1, n_rx > 3)
    `CHK("tx_kept", 1, n_tx)
    rchk("baud_tf", TMR2_IDX_MAIN, 8'h24);
    // clock out: pin driven and toggling on overflows
    wreg(TMR2_IDX_MAIN, 8'h00);
    wreg(TMR2_IDX_MODE, 8'h02);
    tog0 = n_tog;
    wreg(TMR2_IDX_MAIN, 8'h04);
    repeat (100) @(posedge clk_sys);
    `CHK("co_oe", 1'b0, oe_n)
    `CHK("co_tog", 1'b1, (n_tog - tog0) > 2)
    // prescaled reload: 16 ticks of two clocks each before the overflow flag
    wreg(TMR2_IDX_MAIN, 8'h00);
    wreg(TMR2_IDX_MODE, 8'h00);
    wreg(TMR2_IDX_CLKCFG, 8'h11);
    rchk("cfg_rd", TMR2_IDX_CLKCFG, 8'h11);
    wreg(TMR2_IDX_CNT_LO, 8'hF0);
    wreg(TMR2_IDX_CNT_HI, 8'hFF);
    wreg(TMR2_IDX_MAIN, 8'h04);
    n_cyc = 0;
    while (irq !== 1'b1 && n_cyc < 200)
    begin
      @(posedge clk_sys);
      n_cyc++;
    end
    `CHK("ps_period", 1'b1, n_cyc >= 31 && n_cyc <= 34)
    summarize();
  end
endmodule : tb_timer2_capture_reload_counter
